//--- hdl/sbsc_burst_counter.sv
// two-bit wrapping burst counter, linear or interleaved order
// assumes load and advance are never high together
module sbsc_burst_counter (
   // link to cycle control
   sbsc_burst_if.counter bus
);
   import sbsc_pkg::*;

   sbsc_offset_t start;
   sbsc_offset_t count;

   function automatic sbsc_offset_t order(input logic lin, input sbsc_offset_t s,
                                          input sbsc_offset_t c);
      return lin ? sbsc_offset_t'(s + c) : (s ^ c);
   endfunction

   always_ff @(posedge bus.clk_sys or negedge bus.reset_n) begin
      if (!bus.reset_n) begin
         start <= 2'h0;
         count <= 2'h0;
      end else if (bus.load) begin
         start <= bus.seed;
         count <= 2'h0;
      end else if (bus.advance) begin
         count <= sbsc_offset_t'(count + 2'h1);
      end
   end

   assign bus.offset_cur = order(bus.linear, start, count);
   assign bus.offset_next = order(bus.linear, start, sbsc_offset_t'(count + 2'h1));

endmodule // sbsc_burst_counter

//--- hdl/sbsc_burst_if.sv
// carrier between cycle control and the burst counter
// assumes both ends share clk_sys and reset_n
interface sbsc_burst_if (
   input wire logic clk_sys,
   input wire logic reset_n
);
   logic load;
   logic advance;
   logic linear;
   sbsc_pkg::sbsc_offset_t seed;
   sbsc_pkg::sbsc_offset_t offset_cur;
   sbsc_pkg::sbsc_offset_t offset_next;

   modport ctrl (
      input clk_sys, reset_n, offset_cur, offset_next,
      output load, advance, linear, seed
   );
   modport counter (
      input clk_sys, reset_n, load, advance, linear, seed,
      output offset_cur, offset_next
   );
endinterface : sbsc_burst_if

//--- hdl/sbsc_cycle_control.sv
// cycle control, byte-lane writes and data pin control of a burst sram
// assumes the partner drives all synchronous inputs from clk_sys;
// sleep_request and burst_order_linear_n are asynchronous pins
`include "sbsc_params.svh"

// Functional notes
// - bad select with a controller strobe, or with either strobe while primary select low, deselects, floats
// - processor strobe start always reads external address
// - processor strobe start cycle never writes
// - controller strobe start writes or reads externally
// - no strobe, advance low, reads next address
// - no strobe, advance low, writes next address
// - advance high repeats access at current address
// - read only when global write high and byte gate or all lane writes high, or on any processor strobe start
// - byte gate low with global write high writes low lanes only
// - global write low writes all lanes
// - pin direction from cycle and output enable
// - write cycles mask output enable
// - selected read drives when output enable low
// - sleep: async, two cycles in, out
// - two-bit burst counter, linear or interleaved
// - data one edge later, float after deselect
module sbsc_cycle_control #(
   parameter int ADDR_W = `SBSC_ADDR_W,
   parameter int LANES = `SBSC_LANES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // address and chip selects
   input wire logic [ADDR_W-1:0] address,
   input wire logic chip_select_primary_n,
   input wire logic chip_select_expand_high,
   input wire logic chip_select_expand_n,
   // burst control
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic burst_order_linear_n,
   // write control
   input wire logic global_write_n,
   input wire logic byte_write_gate_n,
   input wire logic [LANES-1:0] byte_lane_write_n,
   // asynchronous controls
   input wire logic output_enable_n,
   input wire logic sleep_request,
   // data pins
   input wire logic [LANES*`SBSC_LANE_BITS-1:0] data_in,
   output logic [LANES*`SBSC_LANE_BITS-1:0] data_out,
   output logic [LANES*`SBSC_LANE_BITS-1:0] data_oe,
   input wire logic [LANES-1:0] parity_in,
   output logic [LANES-1:0] parity_out,
   output logic [LANES-1:0] parity_oe,
   // status
   output logic sleeping
);
   import sbsc_pkg::*;

   localparam int LB = `SBSC_LANE_BITS;
   localparam int WB = LB + 1;
   localparam int HI_W = ADDR_W - `SBSC_BURST_W;

   // lane i occupies {parity, byte} at bits i*WB
   logic [LANES*WB-1:0] mem [2**ADDR_W];

   logic [2:0] sleep_sync;
   logic [2:0] order_sync;
   logic sleep_lvl;
   logic order_lvl;
   sbsc_sleep_e sleep_state;
   logic [`SBSC_SLEEP_CNT_W-1:0] sleep_cnt;
   logic awake;

   sbsc_cycle_e cycle;
   logic [LANES-1:0] lanes_wr;
   logic write_now;
   logic read_now;
   logic [ADDR_W-1:0] eff_addr;
   logic [HI_W-1:0] base;
   logic [ADDR_W-1:0] rd_addr_q;
   logic rd_q;
   logic drive_q;

   sbsc_burst_if bif (.clk_sys(clk_sys), .reset_n(reset_n));

   sbsc_burst_counter u_counter (.bus(bif.counter));

   // lanes written; zero means the cycle reads
   function automatic logic [LANES-1:0] lane_mask(input logic gw_n, input logic bwe_n,
                                                  input logic [LANES-1:0] bw_n);
      if (!gw_n) begin
         return '1;
      end else if (!bwe_n) begin
         return ~bw_n;
      end
      return '0;
   endfunction

   // async pins: three flops, a change counts once stages two and three agree
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sleep_sync <= {3{`SBSC_SLEEP_RESET}};
         order_sync <= {3{`SBSC_ORDER_RESET}};
      end else begin
         sleep_sync <= {sleep_sync[1:0], sleep_request};
         order_sync <= {order_sync[1:0], burst_order_linear_n};
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sleep_lvl <= `SBSC_SLEEP_RESET;
         order_lvl <= `SBSC_ORDER_RESET;
      end else begin
         if (sleep_sync[1] == sleep_sync[2]) begin
            sleep_lvl <= sleep_sync[2];
         end
         if (order_sync[1] == order_sync[2]) begin
            order_lvl <= order_sync[2];
         end
      end
   end

   // sleep sequencing; accesses in flight at entry are simply dropped
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sleep_state <= SBSC_SLP_AWAKE;
         sleep_cnt <= '0;
      end else begin
         unique case (sleep_state)
            SBSC_SLP_AWAKE: begin
               sleep_cnt <= '0;
               if (sleep_lvl) begin
                  sleep_state <= SBSC_SLP_ENTER;
               end
            end
            SBSC_SLP_ENTER: begin
               sleep_cnt <= sleep_cnt + 1'b1;
               if (sleep_cnt == `SBSC_SLEEP_CNT_W'(`SBSC_SLEEP_ENTER_CYC - 1)) begin
                  sleep_state <= SBSC_SLP_ASLEEP;
                  sleep_cnt <= '0;
               end
            end
            SBSC_SLP_ASLEEP: begin
               if (!sleep_lvl) begin
                  sleep_state <= SBSC_SLP_WAKE;
               end
            end
            SBSC_SLP_WAKE: begin
               sleep_cnt <= sleep_cnt + 1'b1;
               if (sleep_cnt == `SBSC_SLEEP_CNT_W'(`SBSC_SLEEP_EXIT_CYC - 1)) begin
                  sleep_state <= SBSC_SLP_AWAKE;
                  sleep_cnt <= '0;
               end
            end
         endcase
      end
   end

   assign awake = (sleep_state == SBSC_SLP_AWAKE);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sleeping <= 1'b0;
      end else begin
         sleeping <= (sleep_state != SBSC_SLP_AWAKE);
      end
   end

   // cycle type, sampled inputs of this edge
   always_comb begin
      cycle = SBSC_CYC_SUSPEND;
      // with the primary select high a processor strobe is ignored, not a deselect
      if ((chip_select_primary_n && !controller_addr_strobe_n) ||
          (!chip_select_primary_n && (!chip_select_expand_high || chip_select_expand_n) &&
           (!processor_addr_strobe_n || !controller_addr_strobe_n))) begin
         cycle = SBSC_CYC_DESELECT;
      end else if (!chip_select_primary_n && !processor_addr_strobe_n) begin
         cycle = SBSC_CYC_BEGIN_P;
      end else if (!controller_addr_strobe_n) begin
         cycle = SBSC_CYC_BEGIN_C;
      end else if (!burst_advance_n) begin
         cycle = SBSC_CYC_CONTINUE;
      end
   end

   assign lanes_wr = lane_mask(global_write_n, byte_write_gate_n, byte_lane_write_n);
   // a processor strobe start never writes
   assign write_now = awake && (lanes_wr != '0) && (cycle != SBSC_CYC_DESELECT) &&
                      (cycle != SBSC_CYC_BEGIN_P);
   assign read_now = awake && (cycle != SBSC_CYC_DESELECT) && !write_now;

   always_comb begin
      unique case (cycle)
         SBSC_CYC_BEGIN_P, SBSC_CYC_BEGIN_C: eff_addr = address;
         SBSC_CYC_CONTINUE: eff_addr = {base, bif.offset_next};
         default: eff_addr = {base, bif.offset_cur};
      endcase
   end

   assign bif.load = awake && ((cycle == SBSC_CYC_BEGIN_P) || (cycle == SBSC_CYC_BEGIN_C));
   assign bif.advance = awake && (cycle == SBSC_CYC_CONTINUE);
   assign bif.seed = address[`SBSC_BURST_W-1:0];
   assign bif.linear = !order_lvl;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         base <= '0;
      end else if (bif.load) begin
         base <= address[ADDR_W-1:`SBSC_BURST_W];
      end
   end

   // self-timed write: data and lane masks taken at the same edge
   always_ff @(posedge clk_sys) begin
      if (write_now) begin
         for (int i = 0; i < LANES; i++) begin
            if (lanes_wr[i]) begin
               mem[eff_addr][i*WB +: WB] <= {parity_in[i], data_in[i*LB +: LB]};
            end
         end
      end
   end

   // read pipeline: address registered now, data out at the next edge
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rd_q <= 1'b0;
         rd_addr_q <= '0;
      end else begin
         rd_q <= read_now;
         if (read_now) begin
            rd_addr_q <= eff_addr;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         data_out <= '0;
         parity_out <= '0;
      end else if (rd_q) begin
         for (int i = 0; i < LANES; i++) begin
            data_out[i*LB +: LB] <= mem[rd_addr_q][i*WB +: LB];
            parity_out[i] <= mem[rd_addr_q][i*WB + LB];
         end
      end
   end

   // deselect floats at once; a write masks the drivers for its cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= rd_q && awake && (cycle != SBSC_CYC_DESELECT) && !write_now;
      end
   end

   // output enable is a pin acting without the clock, so this path is gated
   always_comb begin
      data_oe = {(LANES*LB){drive_q && awake && !output_enable_n}};
      parity_oe = {LANES{drive_q && awake && !output_enable_n}};
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   desel_float_a: assert property ((awake && cycle == SBSC_CYC_DESELECT) |=> !drive_q)
      else $error("data pins drive after a deselect");
   processor_addr_strobe_n_read_a: assert property ((awake && cycle == SBSC_CYC_BEGIN_P) |=> rd_q &&
                                 rd_addr_q == $past(address))
      else $error("processor strobe start did not read the external address");
   processor_addr_strobe_n_no_write_a: assert property ((cycle == SBSC_CYC_BEGIN_P) |-> !write_now)
      else $error("write taken on a processor strobe start");
   controller_addr_strobe_n_write_a: assert property ((awake && cycle == SBSC_CYC_BEGIN_C &&
                                   lanes_wr != '0) |-> write_now && eff_addr == address)
      else $error("controller strobe write missed");
   burst_next_a: assert property ((awake && cycle == SBSC_CYC_CONTINUE) |=>
                                  bif.offset_cur == $past(bif.offset_next))
      else $error("burst counter did not step");
   cont_write_a: assert property ((awake && cycle == SBSC_CYC_CONTINUE &&
                                   lanes_wr != '0) |-> write_now && eff_addr[1:0] == bif.offset_next)
      else $error("continue write at wrong address");
   suspend_hold_a: assert property ((awake && cycle == SBSC_CYC_SUSPEND) |=>
                                    $stable(bif.offset_cur))
      else $error("burst address moved during suspend");
   read_qual_a: assert property ((lanes_wr == '0) == (global_write_n &&
                                 (byte_write_gate_n || (&byte_lane_write_n))))
      else $error("write qualifier decode wrong");
   write_float_a: assert property (write_now |=> !drive_q ##1 !(|data_oe))
      else $error("data pins drive during a write");
   oe_gate_a: assert property ((drive_q && awake) |-> (data_oe[0] == !output_enable_n))
      else $error("output enable not followed during read");
   sleep_enter_a: assert property ((sleep_state == SBSC_SLP_AWAKE ##1
                                    sleep_state == SBSC_SLP_ENTER) |-> ##1
                                   sleep_state == SBSC_SLP_ENTER ##1 sleep_state == SBSC_SLP_ASLEEP)
      else $error("sleep entry not two cycles");
   read_late_a: assert property ((read_now ##1 (awake && cycle != SBSC_CYC_DESELECT &&
                                  !write_now)) |=> drive_q)
      else $error("read data not driven one edge later");

   processor_addr_strobe_n_then_write_c: cover property (cycle == SBSC_CYC_BEGIN_P ##1 write_now);
   burst_four_c: cover property (bif.load ##1 bif.advance [*3]);
   sleep_round_c: cover property (sleep_state == SBSC_SLP_ASLEEP ##1 sleep_state == SBSC_SLP_WAKE);

endmodule // sbsc_cycle_control

//--- hdl/sbsc_params.svh
// constants for the burst sram cycle control
// assumes a single 10 MHz system clock
`ifndef SBSC_PARAMS_SVH
`define SBSC_PARAMS_SVH

`define SBSC_ADDR_W 19
`define SBSC_LANES 4
`define SBSC_LANE_BITS 8
`define SBSC_BURST_W 2
`define SBSC_SLEEP_ENTER_CYC 2
`define SBSC_SLEEP_EXIT_CYC 2
`define SBSC_SLEEP_CNT_W 2
`define SBSC_SLEEP_RESET 1'h0
`define SBSC_ORDER_RESET 1'h1

`endif

//--- hdl/sbsc_pkg.sv
// types shared by the burst sram cycle control
// assumes nothing beyond the params header
package sbsc_pkg;

   typedef enum logic [2:0] {
      SBSC_CYC_DESELECT = 3'h0,
      SBSC_CYC_BEGIN_P = 3'h1,
      SBSC_CYC_BEGIN_C = 3'h3,
      SBSC_CYC_CONTINUE = 3'h2,
      SBSC_CYC_SUSPEND = 3'h6
   } sbsc_cycle_e;

   typedef enum logic [1:0] {
      SBSC_SLP_AWAKE = 2'h0,
      SBSC_SLP_ENTER = 2'h1,
      SBSC_SLP_ASLEEP = 2'h3,
      SBSC_SLP_WAKE = 2'h2
   } sbsc_sleep_e;

   typedef logic [1:0] sbsc_offset_t;

endpackage : sbsc_pkg

//--- tb/sbsc_host_model.sv
// host bus driver for the burst sram, with reference memory and expected reads
// assumes one cyc call a clock; the bench pops exp_q when the pins drive
module sbsc_host_model (
   // clock
   input wire logic clk_sys,
   // bus to the sram
   output logic [5:0] address,
   output logic chip_select_primary_n,
   output logic chip_select_expand_high,
   output logic chip_select_expand_n,
   output logic processor_addr_strobe_n,
   output logic controller_addr_strobe_n,
   output logic burst_advance_n,
   output logic burst_order_linear_n,
   output logic global_write_n,
   output logic byte_write_gate_n,
   output logic [3:0] byte_lane_write_n,
   output logic output_enable_n,
   output logic sleep_request,
   output logic [31:0] data_in,
   output logic [3:0] parity_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [35:0] mem [64];
   logic [35:0] exp_q [$];
   logic [35:0] pend;
   logic [5:0] base = 6'h00;
   logic [1:0] cnt = 2'h0;
   logic [7:0] lfsr = 8'h4C;
   logic [35:0] show;
   logic pend_v = 1'b0;
   logic show_v = 1'b0;
   logic lin = 1'b0;

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   initial begin
      {chip_select_primary_n, chip_select_expand_high, chip_select_expand_n} = 3'h6;
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h5;
      {global_write_n, byte_write_gate_n, byte_lane_write_n} = 6'h3F;
      {address, burst_order_linear_n, output_enable_n, sleep_request} = 9'h006;
      {parity_in, data_in} = 36'h0;
   end

   // cs = {primary_n, expand_high, expand_n}, st = {proc_n, ctrl_n, adv_n}
   task automatic cyc(input logic [5:0] a, input logic [2:0] cs, input logic [2:0] st,
                      input logic [5:0] wr, input logic oe);
      logic desel;
      logic pstart;
      logic [3:0] m;
      logic [35:0] w;
      logic [5:0] ad;
      @(posedge clk_sys);
      desel = (cs[2] & ~st[1]) | (~cs[2] & (~cs[1] | cs[0]) & ~(st[2] & st[1]));
      pstart = ~cs[2] & ~st[2];
      m = ~wr[5] ? 4'hF : (~wr[4] ? ~wr[3:0] : 4'h0);
      for (int i = 0; i < 5; i++) begin
         lfsr = lfsr_next(lfsr);
         w = {w[27:0], lfsr};
      end
      // read of two calls back drives now if the call between read too and enable is low
      if (show_v && !oe) exp_q.push_back(show);
      show_v = 1'b0;
      if (desel) begin
         pend_v = 1'b0;
      end else begin
         if (pstart | ~st[1]) begin
            base = a;
            cnt = 2'h0;
         end else if (~st[0]) begin
            cnt = cnt + 2'h1;
         end
         ad = {base[5:2], lin ? base[1:0] + cnt : base[1:0] ^ cnt};
         if (!pstart && m != 4'h0) begin
            pend_v = 1'b0;
            for (int i = 0; i < 4; i++) begin
               if (m[i]) begin
                  mem[ad][8*i +: 8] = w[8*i +: 8];
                  mem[ad][32+i] = w[32+i];
               end
            end
         end else begin
            show_v = pend_v;
            show = pend;
            pend_v = 1'b1;
            pend = mem[ad];
         end
      end
      address <= a;
      {chip_select_primary_n, chip_select_expand_high, chip_select_expand_n} <= cs;
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= st;
      {global_write_n, byte_write_gate_n, byte_lane_write_n} <= wr;
      output_enable_n <= oe;
      {parity_in, data_in} <= w;
   endtask

   task automatic set_order(input logic v);
      @(posedge clk_sys);
      burst_order_linear_n <= v;
      lin = ~v;
   endtask

   task automatic doze(input logic v);
      @(posedge clk_sys);
      sleep_request <= v;
      pend_v = 1'b0;
      show_v = 1'b0;
   endtask
endmodule // sbsc_host_model

//--- tb/testbench.sv
// self-checking bench of the burst sram cycle control
// assumes sbsc_host_model drives every input but clk_sys and reset_n and holds the expected reads
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [2:0] SEL = 3'h2;
   localparam logic [2:0] PST = 3'h3;
   localparam logic [2:0] CST = 3'h5;
   localparam logic [2:0] CONT = 3'h6;
   localparam logic [2:0] SUSP = 3'h7;
   localparam logic [5:0] RD = 6'h3F;
   localparam logic [5:0] GWR = 6'h1F;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [5:0] address;
   logic cs1_n, cs2, cs3_n, ps_n, cs_n, adv_n, ord_n, gw_n, bwe_n, oe_n, slp, sleeping;
   logic [3:0] bw_n, parity_in, parity_out, parity_oe;
   logic [31:0] data_in, data_out, data_oe;
   logic [35:0] want;
   int err_total = 0;
   int samples_checked = 0;
   int n;

   initial forever #50 clk_sys = ~clk_sys;

   sbsc_cycle_control #(.ADDR_W(6), .LANES(4)) dut_u (
      .clk_sys(clk_sys), .reset_n(reset_n), .address(address),
      .chip_select_primary_n(cs1_n), .chip_select_expand_high(cs2),
      .chip_select_expand_n(cs3_n), .processor_addr_strobe_n(ps_n),
      .controller_addr_strobe_n(cs_n), .burst_advance_n(adv_n),
      .burst_order_linear_n(ord_n), .global_write_n(gw_n), .byte_write_gate_n(bwe_n),
      .byte_lane_write_n(bw_n), .output_enable_n(oe_n), .sleep_request(slp),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .parity_in(parity_in),
      .parity_out(parity_out), .parity_oe(parity_oe), .sleeping(sleeping));

   sbsc_host_model partner_u (
      .clk_sys(clk_sys), .address(address), .chip_select_primary_n(cs1_n),
      .chip_select_expand_high(cs2), .chip_select_expand_n(cs3_n),
      .processor_addr_strobe_n(ps_n), .controller_addr_strobe_n(cs_n),
      .burst_advance_n(adv_n), .burst_order_linear_n(ord_n), .global_write_n(gw_n),
      .byte_write_gate_n(bwe_n), .byte_lane_write_n(bw_n), .output_enable_n(oe_n),
      .sleep_request(slp), .data_in(data_in), .parity_in(parity_in));

   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp || $isunknown(seen)) begin
         err_total++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic idle(input int k);
      repeat (k) partner_u.cyc(6'h00, 3'h6, CST, RD, 1'b0);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   // drive seen mid-cycle: either a noted read or nothing at all
   always @(negedge clk_sys) begin
      if (reset_n && (data_oe !== 32'h0 || parity_oe !== 4'h0)) begin
         chk(36'(partner_u.exp_q.size() != 0), 36'h1);
         if (partner_u.exp_q.size() != 0) begin
            want = partner_u.exp_q.pop_front();
            chk({parity_oe, data_oe}, 36'hF_FFFF_FFFF);
            chk({parity_out, data_out}, want);
         end
      end
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      err_total++;
      end_of_test();
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      idle(4);
      partner_u.cyc(6'h0A, SEL, CST, GWR, 1'b1);
      // selects bad and a stray processor strobe during continues: all ignored
      partner_u.cyc(6'h00, 3'h5, 3'h2, GWR, 1'b1);
      repeat (2) partner_u.cyc(6'h00, 3'h5, CONT, GWR, 1'b1);
      done("burst write");
      partner_u.cyc(6'h09, SEL, PST, 6'h00, 1'b0);
      repeat (3) partner_u.cyc(6'h00, 3'h5, CONT, RD, 1'b0);
      partner_u.cyc(6'h00, 3'h5, SUSP, RD, 1'b1);
      repeat (2) partner_u.cyc(6'h00, SEL, SUSP, RD, 1'b0);
      partner_u.cyc(6'h0B, SEL, PST, RD, 1'b0);
      partner_u.cyc(6'h00, 3'h5, SUSP, GWR, 1'b1);
      partner_u.cyc(6'h0B, SEL, PST, RD, 1'b0);
      repeat (2) partner_u.cyc(6'h00, SEL, SUSP, RD, 1'b0);
      done("burst read and suspend");
      for (int m = 0; m < 17; m++) begin
         partner_u.cyc(6'h0C, SEL, CST, m == 16 ? 6'h30 : {2'h2, 4'(m)}, 1'b1);
         partner_u.cyc(6'h0C, SEL, PST, RD, 1'b0);
         repeat (2) partner_u.cyc(6'h0C, SEL, SUSP, RD, 1'b0);
      end
      done("byte lanes");
      for (int f = 0; f < 3; f++) begin
         partner_u.cyc(6'h0D, SEL, CST, GWR, 1'b1);
         partner_u.cyc(6'h0D, SEL, PST, RD, 1'b0);
         partner_u.cyc(6'h00, f == 0 ? 3'h6 : (f == 1 ? 3'h0 : 3'h3), f == 1 ? PST : CST,
                       RD, 1'b0);
         partner_u.cyc(6'h0D, SEL, PST, RD, 1'b0);
         repeat (2) partner_u.cyc(6'h00, SEL, SUSP, RD, 1'b0);
      end
      done("deselect");
      // a held read would repeat while the mode pin changes
      idle(1);
      partner_u.set_order(1'b0);
      idle(6);
      partner_u.cyc(6'h09, SEL, CST, RD, 1'b0);
      repeat (3) partner_u.cyc(6'h00, SEL, CONT, RD, 1'b0);
      partner_u.cyc(6'h00, SEL, SUSP, RD, 1'b0);
      idle(2);
      done("linear order");
      partner_u.doze(1'b1);
      n = 0;
      while (sleeping !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      chk(36'(n >= 2 && n <= 10), 36'h1);
      chk({parity_oe, data_oe}, 36'h0);
      partner_u.doze(1'b0);
      n = 0;
      while (sleeping !== 1'b0 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      chk(36'(n >= 2 && n <= 10), 36'h1);
      idle(3);
      partner_u.cyc(6'h0D, SEL, PST, RD, 1'b0);
      repeat (2) partner_u.cyc(6'h00, SEL, SUSP, RD, 1'b0);
      idle(3);
      done("sleep");
      chk(36'(partner_u.exp_q.size()), 36'h0);
      end_of_test();
   end
endmodule // testbench
